// ==== shared/scs_pkg.sv ====
// Package for the vector control/status state block: field layout,
// reset values, save-image layout and carrier types.
// Assumes one core clock and a synchronous active-high reset.
`default_nettype none

package scs_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Control/status field layout
   localparam int unsigned CSR_W      = 32;
   localparam int unsigned FLAG_LO    = 0;
   localparam int unsigned FLAG_HI    = 5;
   localparam int unsigned DZE_BIT    = 6;
   localparam int unsigned EMASK_LO   = 7;
   localparam int unsigned EMASK_HI   = 12;
   localparam int unsigned RC_LO      = 13;
   localparam int unsigned RC_HI      = 14;
   localparam int unsigned FTZ_BIT    = 15;
   localparam int unsigned NUM_FLAGS  = 6;

   localparam logic [31:0] CSR_RST      = 32'h0000_1F80;
   localparam logic [1:0]  RC_NEAREST   = 2'h0;
   localparam logic [31:0] MASK_NONE    = 32'h0000_0000;
   localparam logic [31:0] MASK_DEFAULT = 32'h0000_FFBF;
   localparam logic [31:0] MASK_FULL    = 32'h0000_FFFF;

   ////////////////////////////////////////////////////////////////////////
   // Vector registers and 512-byte save image (32 beats of 16 bytes)
   localparam int unsigned VEC_W      = 128;
   localparam int unsigned NUM_VREGS  = 8;
   localparam int unsigned VIDX_W     = 3;
   localparam int unsigned IMG_BYTES  = 512;
   localparam int unsigned IMG_BEATS  = IMG_BYTES / (VEC_W / 8);
   localparam int unsigned BEAT_W     = 5;
   localparam logic [4:0]  CSR_BEAT   = 5'h01;
   localparam logic [4:0]  VEC_BEAT0  = 5'h0A;
   localparam logic [4:0]  VEC_BEATN  = 5'h11;
   localparam logic [4:0]  LAST_BEAT  = 5'h1F;
   localparam int unsigned CSR_LSB    = 64;
   localparam int unsigned SMASK_LSB  = 96;

   typedef struct packed {
      logic [VIDX_W-1:0] idx;
      logic [VEC_W-1:0]  data;
   } scs_vwr_t;

   typedef struct packed {
      logic [BEAT_W-1:0] idx;
      logic [VEC_W-1:0]  data;
   } scs_beat_t;

   typedef enum logic [0:0] {
      SEQ_IDLE,
      SEQ_SAVE
   } scs_seq_t;

   // Mask that governs writes: a zero report means the default mask
   function automatic logic [31:0] eff_mask(input logic [31:0] reported);
      eff_mask = (reported == MASK_NONE) ? MASK_DEFAULT : reported;
   endfunction

   function automatic logic rsvd_hit(input logic [31:0] val, input logic [31:0] reported);
      rsvd_hit = |(val & ~eff_mask(reported));
   endfunction

endpackage

`default_nettype wire

// ==== logic/scs_state.sv ====
// Vector unit architectural state: control/status register, eight
// 128-bit vector registers, save/restore image sequencing.
// Assumes the scalar unit answers fp_idx with fp_data in the same cycle.
//
// Operation
// R1: Hardware reset loads control/status with 1F80H
// R2: Reset sets exception mask bits 7-12
// R3: Reset clears sticky flags bits 0-5
// R4: Reset sets rounding field to nearest
// R5: Reset clears flush-to-zero bit 15
// R6: Reset clears denormal-zero bit 6
// R7: Reset clears all eight vector registers
// R8: Soft init leaves all state unchanged
// R9: Reserved-bit write faults, register not updated
// R10: Save writes image; restore reloads it
// R11: Mask: ones implemented, zeros reserved
// R12: Unsupported denormal-zero may report zero mask
// R13: Zero report means effective mask 0000FFBFH
// R14: Nonzero mask bit 6 means mode present
// R15: Software ANDs writes with effective mask
// R16: Vector file separate from scalar registers
// R17: Software orders multimedia/scalar transitions
// R18: Native precision, no widening
// R19: Mask is fixed read-only constant; mask_r reads zero in reset and until the first clock edge after release
`timescale 1ns/10ps
`default_nettype none

module scs_state #(
   parameter logic DZE_SUPPORTED = 1'b1
) (
   input  wire logic                       core_clk,
   input  wire logic                       srst,
   input  wire logic                       soft_init,
   input  wire logic                       ld_valid,
   input  wire logic [31:0]                ld_data,
   input  wire logic [scs_pkg::NUM_FLAGS-1:0] exc_flags,
   input  wire logic                       vw_valid,
   input  wire scs_pkg::scs_vwr_t          vw,
   input  wire logic [scs_pkg::VIDX_W-1:0] vr_idx,
   input  wire logic                       save_req,
   input  wire logic [scs_pkg::VEC_W-1:0]  fp_data,
   input  wire logic                       rst_valid,
   input  wire scs_pkg::scs_beat_t         rst_beat,
   output logic [31:0]                     csr_q,
   output logic [31:0]                     mask_q,
   output logic [scs_pkg::VEC_W-1:0]       vr_data,
   output logic                            fault,
   output logic                            save_busy,
   output logic [scs_pkg::BEAT_W-1:0]      fp_idx,
   output logic                            img_valid,
   output scs_pkg::scs_beat_t              img
);

   ////////////////////////////////////////////////////////////////////////
   // Fixed supported-bits mask
   // Zero report when denormal-zero absent keeps old software happy
   localparam logic [31:0] REPORTED_MASK =
      DZE_SUPPORTED ? scs_pkg::MASK_FULL : scs_pkg::MASK_NONE; // see R11, R12, R14, R19

   // Beat decode shared by restore, save and checks
   function automatic logic vec_beat(input logic [scs_pkg::BEAT_W-1:0] idx);
      vec_beat = idx >= scs_pkg::VEC_BEAT0 && idx <= scs_pkg::VEC_BEATN;
   endfunction

   function automatic logic [scs_pkg::VIDX_W-1:0] vec_slot(input logic [scs_pkg::BEAT_W-1:0] idx);
      vec_slot = 3'(idx - scs_pkg::VEC_BEAT0);
   endfunction

   logic [31:0]                  csr_r;
   logic [31:0]                  csr_nxt;
   logic [31:0]                  mask_r;
   logic [scs_pkg::VEC_W-1:0]    vreg_r [scs_pkg::NUM_VREGS];
   logic [scs_pkg::VEC_W-1:0]    vr_data_r;
   logic                         fault_r;
   scs_pkg::scs_seq_t            seq_r;
   logic [scs_pkg::BEAT_W-1:0]   cnt_r;
   logic                         img_valid_r;
   logic                         busy_r;
   scs_pkg::scs_beat_t           img_r;

   logic                         rst_csr;
   logic                         rst_vec;
   logic                         ld_bad;
   logic                         rst_bad;
   logic [scs_pkg::VIDX_W-1:0]   rst_vidx;
   logic [scs_pkg::VIDX_W-1:0]   save_vidx;

   // Restores are refused while a save streams out
   assign rst_csr  = rst_valid && seq_r == scs_pkg::SEQ_IDLE && rst_beat.idx == scs_pkg::CSR_BEAT;
   assign rst_vec  = rst_valid && seq_r == scs_pkg::SEQ_IDLE && vec_beat(rst_beat.idx);
   assign ld_bad   = ld_valid && scs_pkg::rsvd_hit(ld_data, REPORTED_MASK); // see R9, R13
   assign rst_bad  = rst_csr && scs_pkg::rsvd_hit(rst_beat.data[scs_pkg::CSR_LSB +: 32], REPORTED_MASK);
   assign rst_vidx = vec_slot(rst_beat.idx);
   assign save_vidx = vec_slot(cnt_r);

   ////////////////////////////////////////////////////////////////////////
   // Control/status register
   always_comb begin
      csr_nxt = csr_r;
      if (rst_csr && !rst_bad) begin
         csr_nxt = rst_beat.data[scs_pkg::CSR_LSB +: 32]; // see R10
      end else if (ld_valid && !ld_bad) begin
         csr_nxt = ld_data;
      end
      // A flag raised in the cycle of a load survives it
      csr_nxt[scs_pkg::FLAG_HI:scs_pkg::FLAG_LO] = csr_nxt[scs_pkg::FLAG_HI:scs_pkg::FLAG_LO] | exc_flags;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         csr_r <= scs_pkg::CSR_RST; // see R1, R2, R3, R4, R5, R6
      end else begin
         csr_r <= csr_nxt; // see R8, R9
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         fault_r <= 1'b0;
      end else begin
         fault_r <= ld_bad || rst_bad; // see R9
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         mask_r <= 32'h0000_0000;
      end else begin
         mask_r <= REPORTED_MASK; // see R19
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Vector register file, private to the vector unit
   // Results arrive already in native width; nothing here widens them
   always_ff @(posedge core_clk) begin
      if (srst) begin
         for (int i = 0; i < scs_pkg::NUM_VREGS; i++) begin
            vreg_r[i] <= '0; // see R7
         end
      end else begin
         if (vw_valid) begin
            vreg_r[vw.idx] <= vw.data; // see R16, R18
         end
         // Restore placed last: it wins on the same slot, other slots keep the write
         if (rst_vec) begin
            vreg_r[rst_vidx] <= rst_beat.data; // see R10
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         vr_data_r <= '0;
      end else begin
         vr_data_r <= vreg_r[vr_idx];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Save image sequencer: one 16-byte beat per cycle, 32 beats
   always_ff @(posedge core_clk) begin
      if (srst) begin
         seq_r <= scs_pkg::SEQ_IDLE;
         cnt_r <= '0;
      end else begin
         case (seq_r)
            scs_pkg::SEQ_IDLE: begin
               cnt_r <= '0;
               if (save_req) begin
                  seq_r <= scs_pkg::SEQ_SAVE;
               end
            end
            scs_pkg::SEQ_SAVE: begin
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == scs_pkg::LAST_BEAT) begin
                  seq_r <= scs_pkg::SEQ_IDLE;
               end
            end
            default: begin
               seq_r <= scs_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

   // Own flop so the busy output carries no decode
   always_ff @(posedge core_clk) begin
      if (srst) begin
         busy_r <= 1'b0;
      end else if (seq_r == scs_pkg::SEQ_IDLE) begin
         busy_r <= save_req;
      end else begin
         busy_r <= cnt_r != scs_pkg::LAST_BEAT;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         img_valid_r <= 1'b0;
         img_r       <= '0;
      end else begin
         img_valid_r <= seq_r == scs_pkg::SEQ_SAVE;
         img_r.idx   <= cnt_r;
         if (cnt_r == scs_pkg::CSR_BEAT) begin
            img_r.data <= {mask_r, csr_r, fp_data[63:0]}; // see R10, R11
         end else if (vec_beat(cnt_r)) begin
            img_r.data <= vreg_r[save_vidx]; // see R10
         end else begin
            img_r.data <= fp_data;
         end
      end
   end

   assign csr_q     = csr_r;
   assign mask_q    = mask_r;
   assign vr_data   = vr_data_r;
   assign fault     = fault_r;
   assign save_busy = busy_r;
   assign fp_idx    = cnt_r;
   assign img_valid = img_valid_r;
   assign img       = img_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   int unsigned save_len;
   always_ff @(posedge core_clk) begin
      if (srst || !img_valid_r) begin
         save_len <= 0;
      end else begin
         save_len <= save_len + 1;
      end
   end

   // Reset values
   a_reset_value: assert property (@(posedge core_clk) // see R1
      srst |=> csr_r == scs_pkg::CSR_RST)
      else $error("control/status not 1F80 after reset");

   a_reset_masks: assert property (@(posedge core_clk) // see R2, R3
      srst |=> csr_r[scs_pkg::EMASK_HI:scs_pkg::EMASK_LO] == 6'h3F && csr_r[scs_pkg::FLAG_HI:0] == 6'h00)
      else $error("mask or flag bits wrong after reset");

   a_reset_modes: assert property (@(posedge core_clk) // see R4, R5, R6
      srst |=> csr_r[scs_pkg::RC_HI:scs_pkg::RC_LO] == scs_pkg::RC_NEAREST && !csr_r[scs_pkg::FTZ_BIT]
      && !csr_r[scs_pkg::DZE_BIT])
      else $error("mode bits wrong after reset");

   // Second cycle after release: the read flop then shows the file, not its own reset
   a_vreg_zero: assert property (@(posedge core_clk) disable iff (srst) // see R7
      $past(srst, 2) && !$past(srst) |-> vr_data_r == '0)
      else $error("vector register not zero after reset");

   // Loads, restores and faults
   a_rsvd_fault: assert property (@(posedge core_clk) disable iff (srst) // see R9
      ld_valid && |(ld_data & ~scs_pkg::eff_mask(REPORTED_MASK)) && !rst_csr
      |=> fault_r && csr_r[31:6] == $past(csr_r[31:6]))
      else $error("reserved write not faulted or register changed");

   a_default_mask: assert property (@(posedge core_clk) disable iff (srst) // see R13
      REPORTED_MASK == scs_pkg::MASK_NONE && ld_valid && ld_data[scs_pkg::DZE_BIT] && !rst_csr |=> fault_r)
      else $error("denormal-zero write not refused under default mask");

   a_good_load: assert property (@(posedge core_clk) disable iff (srst) // see R9
      ld_valid && !ld_bad && !rst_csr && exc_flags == '0 |=> csr_r == $past(ld_data) && !fault_r)
      else $error("legal load not applied");

   a_fault_cause: assert property (@(posedge core_clk) disable iff (srst) // see R9
      fault_r |-> $past(ld_valid) || $past(rst_valid))
      else $error("fault without a write");

   a_restore_csr: assert property (@(posedge core_clk) disable iff (srst) // see R10
      rst_csr && !rst_bad && exc_flags == '0 |=> csr_r == $past(rst_beat.data[scs_pkg::CSR_LSB +: 32]))
      else $error("restored control word not applied");

   a_busy_refuse: assert property (@(posedge core_clk) disable iff (srst) // see R10
      seq_r == scs_pkg::SEQ_SAVE && rst_valid && !ld_valid && exc_flags == '0 |=> $stable(csr_r))
      else $error("restore taken during save");

   a_flag_sticky: assert property (@(posedge core_clk) disable iff (srst) // see R3
      exc_flags[0] |=> csr_r[0])
      else $error("raised flag lost");

   a_flags_all: assert property (@(posedge core_clk) disable iff (srst) // see R3
      exc_flags != '0 |=> (csr_r[scs_pkg::FLAG_HI:scs_pkg::FLAG_LO] & $past(exc_flags)) == $past(exc_flags))
      else $error("raised flags not all kept");

   a_init_quiet: assert property (@(posedge core_clk) disable iff (srst) // see R8
      soft_init && !ld_valid && !rst_valid && exc_flags == '0 |=> $stable(csr_r))
      else $error("soft init disturbed control/status");

   // Supported-bits mask
   a_mask_fixed: assert property (@(posedge core_clk) disable iff (srst) // see R19
      !$past(srst) |-> mask_r == REPORTED_MASK && (mask_r == 32'h0 || mask_r[15:0] == 16'hFFFF))
      else $error("supported mask not the fixed constant");

   a_mask_dze: assert property (@(posedge core_clk) disable iff (srst) // see R14
      !$past(srst) |-> mask_r[scs_pkg::DZE_BIT] == DZE_SUPPORTED)
      else $error("mask bit 6 disagrees with denormal-zero support");

   // Vector file
   a_vec_write: assert property (@(posedge core_clk) disable iff (srst) // see R16
      vw_valid && !(rst_vec && rst_vidx == vw.idx) |=> vreg_r[$past(vw.idx)] == $past(vw.data))
      else $error("vector write not stored");

   a_restore_vec: assert property (@(posedge core_clk) disable iff (srst) // see R10
      rst_vec |=> vreg_r[$past(rst_vidx)] == $past(rst_beat.data))
      else $error("restored vector beat not stored");

   a_vec_read: assert property (@(posedge core_clk) disable iff (srst) // see R16
      !$past(srst) |-> vr_data_r == $past(vreg_r[vr_idx]))
      else $error("vector read data wrong");

   // Save image
   a_img_csr: assert property (@(posedge core_clk) disable iff (srst) // see R10, R11
      img_valid_r && img_r.idx == scs_pkg::CSR_BEAT && !$past(ld_valid) && !$past(rst_valid)
      && $past(exc_flags) == '0 |-> img_r.data[scs_pkg::CSR_LSB +: 32] == csr_r
      && img_r.data[scs_pkg::SMASK_LSB +: 32] == mask_r)
      else $error("save image control word wrong");

   a_vec_beats: assert property (@(posedge core_clk) disable iff (srst) // see R10
      img_valid_r && vec_beat(img_r.idx) && !$past(vw_valid) |-> img_r.data == vreg_r[vec_slot(img_r.idx)])
      else $error("save image vector beat wrong");

   a_other_beat: assert property (@(posedge core_clk) disable iff (srst) // see R10
      img_valid_r && img_r.idx != scs_pkg::CSR_BEAT && !vec_beat(img_r.idx) |-> img_r.data == $past(fp_data))
      else $error("save image scalar beat wrong");

   // Length counted in save_len: a 32-long repetition would unroll too slowly
   a_save_len: assert property (@(posedge core_clk) disable iff (srst) // see R10
      save_len <= 32'(scs_pkg::IMG_BEATS))
      else $error("save image longer than 512 bytes");

   a_save_start: assert property (@(posedge core_clk) disable iff (srst) // see R10
      seq_r == scs_pkg::SEQ_IDLE && save_req |=> ##1 img_valid_r && img_r.idx == 5'h00
      ##31 img_valid_r && img_r.idx == scs_pkg::LAST_BEAT ##1 !img_valid_r)
      else $error("save beat sequence wrong");

   a_busy_state: assert property (@(posedge core_clk) disable iff (srst) // see R10
      busy_r == (seq_r == scs_pkg::SEQ_SAVE))
      else $error("busy flag out of step with sequencer");

   a_img_quiet: assert property (@(posedge core_clk) disable iff (srst) // see R10
      !busy_r |=> !img_valid_r)
      else $error("image beat outside a save");

   c_save_run: cover property (@(posedge core_clk) img_valid_r && img_r.idx == scs_pkg::LAST_BEAT);
   c_fault_seen: cover property (@(posedge core_clk) fault_r);
   c_restore_csr: cover property (@(posedge core_clk) rst_csr && !rst_bad);
   c_flag_on_load: cover property (@(posedge core_clk) ld_valid && exc_flags != '0);
   c_restore_busy: cover property (@(posedge core_clk) rst_valid && seq_r == scs_pkg::SEQ_SAVE);

endmodule // scs_state

`default_nettype wire

// ==== tb/tb_simd_control_status_state.sv ====
// Self-checking bench for the vector control/status state block.
// Assumes scs_state and scs_pkg; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none

module tb_simd_control_status_state;
   logic               core_clk, srst, soft_init, ld_valid, vw_valid, save_req, rst_valid;
   logic               fault, fault0, save_busy, img_valid, ldp, rdp, rd;
   logic [31:0]        ld_data, csr_q, mask_q, mask0, ecsr, rs, err_count, compares;
   logic [5:0]         exc_flags;
   logic [2:0]         vr_idx;
   logic [4:0]         fp_idx;
   logic [127:0]       fp_data, vr_data;
   logic [127:0]       vm [8];
   scs_pkg::scs_vwr_t  vw;
   scs_pkg::scs_beat_t rst_beat, img;
   logic [32:0]        lq [$];
   logic [127:0]       vq [$];
   logic [132:0]       iq [$];

   scs_state dut (.core_clk(core_clk), .srst(srst), .soft_init(soft_init), .ld_valid(ld_valid),
      .ld_data(ld_data), .exc_flags(exc_flags), .vw_valid(vw_valid), .vw(vw), .vr_idx(vr_idx),
      .save_req(save_req), .fp_data(fp_data), .rst_valid(rst_valid), .rst_beat(rst_beat), .csr_q(csr_q),
      .mask_q(mask_q), .vr_data(vr_data), .fault(fault), .save_busy(save_busy), .fp_idx(fp_idx),
      .img_valid(img_valid), .img(img));
   // Second copy without denormal-zero support, only mask and fault watched
   scs_state #(.DZE_SUPPORTED(1'b0)) dut_nodz (.core_clk(core_clk), .srst(srst), .soft_init(soft_init),
      .ld_valid(ld_valid), .ld_data(ld_data), .exc_flags(exc_flags), .vw_valid(vw_valid), .vw(vw),
      .vr_idx(vr_idx), .save_req(save_req), .fp_data(fp_data), .rst_valid(rst_valid), .rst_beat(rst_beat),
      .csr_q(), .mask_q(mask0), .vr_data(), .fault(fault0), .save_busy(), .fp_idx(), .img_valid(), .img());

   ////////////////////////////////////////////////////////////////////////////////
   // Scalar-side data, distinct per beat so misplaced beats show
   function automatic logic [127:0] fpd(input logic [4:0] i);
      return {4{3'h5, i, 24'hA5C3E1}};
   endfunction
   assign fp_data = fpd(fp_idx);

   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction

   task automatic chk(input string nm, input logic [132:0] exp, input logic [132:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic complete_run();
      if (err_count == 0 && compares != 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask

   task automatic idle();
      ld_valid = 1'b0;
      vw_valid = 1'b0;
      rst_valid = 1'b0;
      save_req = 1'b0;
      rd = 1'b0;
      exc_flags = 6'h00;
      tick();
   endtask

   // Expected csr: reserved ones refuse the write, flags OR in afterwards
   task automatic csrx(input logic [31:0] v, input logic [5:0] f);
      logic bad;
      bad = |(v & 32'hFFFF_0000);
      if (!bad) ecsr = v;
      ecsr = ecsr | {26'h0, f};
      lq.push_back({bad, ecsr});
   endtask

   task automatic load(input logic [31:0] v, input logic [5:0] f);
      ld_valid = 1'b1;
      ld_data = v;
      exc_flags = f;
      csrx(v, f);
      tick();
   endtask

   task automatic vwr(input logic [2:0] i, input logic [127:0] d);
      vw_valid = 1'b1;
      vw = {i, d};
      vm[i] = d;
      tick();
   endtask

   task automatic rdv(input logic [2:0] i);
      rd = 1'b1;
      vr_idx = i;
      vq.push_back(vm[i]);
      tick();
   endtask

   task automatic rbeat(input logic [4:0] i, input logic [127:0] d);
      rst_valid = 1'b1;
      rst_beat = {i, d};
      if (i == 5'h01) csrx(d[95:64], 6'h00);
      if (i >= 5'h0A && i <= 5'h11) vm[i - 5'h0A] = d;
      tick();
   endtask

   task automatic save();
      int n;
      logic [127:0] f1;
      f1 = fpd(5'h01);
      for (int i = 0; i < 32; i++) begin
         if (i == 1) iq.push_back({5'h01, 32'h0000_FFFF, ecsr, f1[63:0]});
         else if (i >= 10 && i <= 17) iq.push_back({i[4:0], vm[i - 10]});
         else iq.push_back({i[4:0], fpd(i[4:0])});
      end
      save_req = 1'b1;
      tick();
      save_req = 1'b0;
      chk("save_busy", 1, save_busy);
      repeat (4) tick();
      save_req = 1'b1;
      rst_valid = 1'b1;
      rst_beat = {5'h0A, 128'h0};
      tick();
      idle();
      n = 0;
      while (save_busy && n < 100) begin
         tick();
         n++;
      end
      if (n == 100) begin
         err_count++;
         complete_run();
      end
      repeat (3) tick();
      chk("beats_left", 0, iq.size());
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: results appear one edge after the request is taken
   always @(posedge core_clk) begin
      ldp <= ld_valid | (rst_valid & (rst_beat.idx == 5'h01));
      rdp <= rd;
   end

   always @(negedge core_clk) begin
      if (ldp && !srst) begin
         chk("csr", lq[0][31:0], csr_q);
         chk("fault", lq[0][32], fault);
         void'(lq.pop_front());
      end
      if (rdp && !srst) begin
         chk("vreg", vq[0], vr_data);
         void'(vq.pop_front());
      end
      if (img_valid) begin
         chk("img", iq[0], img);
         void'(iq.pop_front());
      end
   end

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial begin
      {soft_init, ld_valid, vw_valid, save_req, rst_valid, rd} = 6'h00;
      {ld_data, exc_flags, vr_idx, vw, rst_beat} = '0;
      srst = 1'b1;
      rs = 32'h0001_1154;
      {err_count, compares} = 64'h0;
      ecsr = 32'h0000_1F80;
      for (int i = 0; i < 8; i++) vm[i] = 128'h0;
      repeat (16) tick();
      chk("csr_reset", 32'h0000_1F80, csr_q);
      srst = 1'b0;
      tick();
      chk("mask", 32'h0000_FFFF, mask_q);
      chk("mask_nodz", 32'h0, mask0);
      for (int i = 0; i < 8; i++) rdv(i[2:0]);
      idle();
      for (int i = 0; i < 8; i++) vwr(i[2:0], {rnd(), rnd(), rnd(), rnd()});
      idle();
      for (int k = 0; k < 6; k++) load(rnd() & 32'h0000_FFFF, (k == 2) ? 6'h24 : 6'h00);
      load(32'h0001_0000 | rnd(), 6'h01);
      load(32'h0000_1FC0, 6'h00);
      chk("fault_nodz", 1, fault0);
      idle();
      soft_init = 1'b1;
      repeat (4) tick();
      soft_init = 1'b0;
      chk("csr_init", ecsr, csr_q);
      for (int i = 0; i < 8; i++) rdv(i[2:0]);
      idle();
      save();
      rbeat(5'h01, {32'h0, 32'h0000_7FC0, 64'h0});
      for (int i = 10; i < 18; i++) rbeat(i[4:0], {rnd(), rnd(), rnd(), rnd()});
      rbeat(5'h01, {32'h0, 32'h0002_0040, 64'h0});
      idle();
      for (int i = 0; i < 8; i++) rdv(i[2:0]);
      idle();
      save();
      complete_run();
   end
endmodule // tb_simd_control_status_state

`default_nettype wire
